// File: scd_regs.vh
// register offsets, field positions and reset values of the system config bank
// assumes an APB slave with 32-bit data, one register per aligned word
`ifndef SCD_REGS_VH
`define SCD_REGS_VH
// register indices as printed, byte address is four times the index
`define SCD_IDX_DRIVE 12'h20E
`define SCD_IDX_CTRL 12'h201
`define SCD_ADDR_DRIVE 14'h0838
`define SCD_ADDR_CTRL 14'h0804
// control register fields
`define SCD_CTRL_PIN_SEL 3
`define SCD_CTRL_PMEM_EN 2
`define SCD_CTRL_DMEM_EN 1
`define SCD_CTRL_CORE_EN 0
// control value held in reset, before the program memory byte is loaded
`define SCD_CTRL_RESET 4'h0
// drive speed fields
`define SCD_DRV_PORT6 2
`define SCD_DRV_GROUP 1
`define SCD_DRV_BUS 0
`define SCD_DRV_RESET 3'h0
// reads of the write-only drive register
`define SCD_DRV_READ 32'h00000000
`endif

// File: scd_apb_decode.v
// apb address decoder for the system config bank
// assumes the byte address of the current apb transfer on paddr
`timescale 1ns/10ps
`include "scd_regs.vh"
module scd_apb_decode (
  // address in
  input wire [13:0] paddr,
  // selects out
  output wire sel_ctrl,
  output wire sel_drive
);
  // word match on each register
  assign sel_ctrl = (paddr[13:2] == `SCD_IDX_CTRL);
  assign sel_drive = (paddr[13:2] == `SCD_IDX_DRIVE);
endmodule // scd_apb_decode

// File: scd_strap_load.v
// captures the control byte from program memory after reset release
// assumes strap_byte is stable while resetn is released
`timescale 1ns/10ps
module scd_strap_load (
  // clock and reset
  input wire mclk,
  input wire resetn,
  // byte from program memory
  input wire [7:0] strap_byte,
  // load request, one pulse
  output reg load,
  output reg [7:0] value
);
  reg done;
  // one load pulse in the second cycle after release, byte taken at the first clock
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      done <= 1'b0;
      load <= 1'b0;
      value <= 8'h00;
    end
    else
    begin
      load <= !done;
      done <= 1'b1;
      if (!done)
        value <= strap_byte;
    end
  end
endmodule // scd_strap_load

// File: scd_config.v
// system control and pin drive speed registers behind an apb slave
// assumes apb master on mclk; strap byte is the fixed program memory byte
//
// How it works
// - bit 3 picks strobe or port line
// - bit 2 enables internal program memory
// - bit 1 enables internal data memory
// - bit 0 enables internal processor core
// - control bits 3..0 read back settings
// - drive bit 1 sets shared group speed
// - drive bit 0 sets bus port speed
// - reset clears all drive bits slow
// - reset clears control, the second clock after release loads it from program memory
`timescale 1ns/10ps
`include "scd_regs.vh"
module scd_config (
  // clock and reset
  input wire mclk,
  input wire resetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [13:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // fixed control byte from program memory
  input wire [7:0] strap_byte,
  // shared pin: strobe or port line
  input wire rw_strobe,
  input wire port4_bit0_line,
  output reg pin_out,
  output reg pin_is_port,
  // enables
  output reg pmem_en,
  output reg dmem_en,
  output reg core_en,
  // drive speeds, 1 = fast
  output reg drive_port6,
  output reg drive_group,
  output reg drive_bus,
  // busy until first clock after reset release, one cycle before control is loaded
  output reg cfg_loading
);
  ////////////////////////////////////////////////////////////////////////
  wire sel_ctrl;
  wire sel_drive;
  wire strap_load;
  wire [7:0] strap_value;
  reg [3:0] ctrl;
  reg [2:0] drive;
  reg [3:0] next_ctrl;
  reg [2:0] next_drive;
  wire wr_acc;
  wire rd_acc;
  scd_apb_decode u_dec (
    .paddr(paddr),
    .sel_ctrl(sel_ctrl),
    .sel_drive(sel_drive)
  );
  scd_strap_load u_strap (
    .mclk(mclk),
    .resetn(resetn),
    .strap_byte(strap_byte),
    .load(strap_load),
    .value(strap_value)
  );
  ////////////////////////////////////////////////////////////////////////
  // access phase, zero wait states
  assign wr_acc = psel && penable && pwrite && pstrb[0];
  assign rd_acc = psel && penable && !pwrite;
  // next register values
  always @*
  begin
    next_ctrl = ctrl;
    next_drive = drive;
    if (strap_load)
      next_ctrl = strap_value[3:0];
    else if (wr_acc && sel_ctrl)
      next_ctrl = pwdata[3:0];
    if (wr_acc && sel_drive)
      next_drive = pwdata[2:0];
  end
  // state registers
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl <= `SCD_CTRL_RESET;
      drive <= `SCD_DRV_RESET;
    end
    else
    begin
      ctrl <= next_ctrl;
      drive <= next_drive;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // apb answer, registered
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(sel_ctrl || sel_drive);
      prdata <= 32'h00000000;
      if (psel && !penable && !pwrite && sel_ctrl)
        prdata <= {28'h0000000, next_ctrl};
      else if (psel && !penable && !pwrite && sel_drive)
        prdata <= `SCD_DRV_READ;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // outputs from flops
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_out <= 1'b0;
      pin_is_port <= 1'b0;
      pmem_en <= 1'b0;
      dmem_en <= 1'b0;
      core_en <= 1'b0;
      drive_port6 <= 1'b0;
      drive_group <= 1'b0;
      drive_bus <= 1'b0;
      cfg_loading <= 1'b1;
    end
    else
    begin
      pin_is_port <= next_ctrl[`SCD_CTRL_PIN_SEL];
      pin_out <= next_ctrl[`SCD_CTRL_PIN_SEL] ? port4_bit0_line : rw_strobe;
      pmem_en <= next_ctrl[`SCD_CTRL_PMEM_EN];
      dmem_en <= next_ctrl[`SCD_CTRL_DMEM_EN];
      core_en <= next_ctrl[`SCD_CTRL_CORE_EN];
      drive_port6 <= next_drive[`SCD_DRV_PORT6];
      drive_group <= next_drive[`SCD_DRV_GROUP];
      drive_bus <= next_drive[`SCD_DRV_BUS];
      cfg_loading <= 1'b0;
    end
  end
  wire unused_ok = rd_acc | (|pstrb[3:1]) | (|pwdata[31:4]) | (|strap_value[7:4]);
endmodule // scd_config

// File: scd_config_monitor.sv
// assertion checker for the system config bank
// assumes binding to scd_config, sees its ports only
`timescale 1ns/10ps
`include "scd_regs.vh"
module scd_config_mon (
  // clock, reset and apb
  input logic mclk, resetn, psel, penable, pwrite, pready,
  input logic [13:0] paddr,
  input logic [31:0] pwdata, prdata,
  input logic [3:0] pstrb,
  // config outputs
  input logic pin_is_port, pmem_en, dmem_en, core_en, drive_port6, drive_group, drive_bus
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // accepted transfers per register
  wire acc = psel && penable && pready;
  wire wc = acc && pwrite && pstrb[0] && paddr == `SCD_ADDR_CTRL;
  wire wd = acc && pwrite && pstrb[0] && paddr == `SCD_ADDR_DRIVE;
  wire rc = acc && !pwrite && paddr == `SCD_ADDR_CTRL;
  property p_sel; wc |=> pin_is_port == $past(pwdata[3]); endproperty
  a_sel: assert property (p_sel) else $error("pin select wrong");
  property p_pm; wc |=> pmem_en == $past(pwdata[2]); endproperty
  a_pm: assert property (p_pm) else $error("pmem_en wrong");
  property p_dm; wc |=> dmem_en == $past(pwdata[1]); endproperty
  a_dm: assert property (p_dm) else $error("dmem_en wrong");
  property p_co; wc |=> core_en == $past(pwdata[0]); endproperty
  a_co: assert property (p_co) else $error("core_en wrong");
  property p_rd; rc |-> prdata[3:0] == {pin_is_port, pmem_en, dmem_en, core_en}; endproperty
  a_rd: assert property (p_rd) else $error("readback wrong");
  property p_d6; wd |=> drive_port6 == $past(pwdata[2]); endproperty
  a_d6: assert property (p_d6) else $error("drive_port6 wrong");
  property p_dg; wd |=> drive_group == $past(pwdata[1]); endproperty
  a_dg: assert property (p_dg) else $error("drive_group wrong");
  property p_db; wd |=> drive_bus == $past(pwdata[0]); endproperty
  a_db: assert property (p_db) else $error("drive_bus wrong");
  // main scenarios
  c_wc: cover property (wc);
  c_wd: cover property (wd);
  c_rc: cover property (rc);
endmodule // scd_config_mon
bind scd_config scd_config_mon u_mon (.*);

// File: system_config_and_drive_strength_tb_top.sv
// apb testbench for the system config bank
// assumes scd_config with a strap byte that changes between the two resets
`timescale 1ns/10ps
`include "scd_regs.vh"
module system_config_and_drive_strength_tb_top;
  logic mclk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, p4 = 0, rws = 0, er;
  logic [13:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0] pstrb = 0;
  logic [7:0] strap = 8'hA5;
  logic pready, pslverr, pin_out, sel, pm, dm, co, d6, dg, db, ld;
  int errors = 0, total_checks = 0, cyc = 0;
  scd_config u_dut (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .strap_byte(strap), .rw_strobe(rws), .port4_bit0_line(p4), .pin_out(pin_out), .pin_is_port(sel),
    .pmem_en(pm), .dmem_en(dm), .core_en(co), .drive_port6(d6), .drive_group(dg), .drive_bus(db),
    .cfg_loading(ld));
  // clock and hang guard
  initial forever #4 mclk = ~mclk;
  always @(posedge mclk)
  begin
    if (++cyc > 3000)
    begin
      errors++;
      finish_test();
    end
  end
  task chk(input string n, input logic [31:0] e, g);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask
  // one apb transfer, waits for pready
  task apb(input logic w, input logic [13:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge mclk);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task step;
    @(posedge mclk);
    #1;
  endtask
  task finish_test;
    if (errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // main sequence, reset run twice
  initial
  begin
    for (int r = 0; r < 2; r++)
    begin
      repeat (3) @(posedge mclk);
      chk("loading", 1, ld);
      chk("rstout", 0, {sel, pm, dm, co, d6, dg, db, pin_out});
      resetn <= 1;
      repeat (2) step();
      chk("loading", 0, ld);
      chk("drive", `SCD_DRV_RESET, {d6, dg, db});
      chk("ctrl", strap[3:0], {sel, pm, dm, co});
      for (int i = 0; i < 16 && r == 0; i++)
      begin
        @(posedge mclk);
        p4 <= ~i[0];
        rws <= i[0];
        apb(1, `SCD_ADDR_CTRL, 32'hFFFFFFF0 | i, 4'hF);
        repeat (2) step();
        chk("ctrl", i, {sel, pm, dm, co});
        chk("pin", i[3] ? !i[0] : i[0], pin_out);
        apb(0, `SCD_ADDR_CTRL, 0, 4'hF);
        chk("read", i, rd[3:0]);
        apb(1, `SCD_ADDR_DRIVE, 32'hFFFFFFF8 | i, 4'hF);
        step();
        chk("drive", i[2:0], {d6, dg, db});
      end
      apb(1, `SCD_ADDR_CTRL, 0, 4'h0);
      step();
      chk("strobe", r ? strap[3:0] : 4'hF, {sel, pm, dm, co});
      apb(0, 14'h0100, 0, 4'hF);
      chk("slverr", 1, er);
      apb(0, `SCD_ADDR_DRIVE, 0, 4'hF);
      chk("drvread", `SCD_DRV_READ, rd);
      resetn <= 0;
      strap <= 8'h3A;
    end
    finish_test();
  end
endmodule // system_config_and_drive_strength_tb_top
